// ==== adc_cmd_cfg.svh ====
/*
  Constants for the serial command-byte decoder and external-clock conversion sequencer.
  Assumes inclusion by the package and the design file only.
*/
`ifndef ADC_CMD_CFG_SVH
`define ADC_CMD_CFG_SVH
`define BIT_POLARITY    6
`define BIT_CLK_SRC     5
`define BIT_MODE_HI     4
`define BIT_MODE_LO     3
`define AUX_RESET       3'h0
`define CMD_RESET       7'h20
`define STROBE_SHORT    6'h07
`define MSB_SHORT       6'h08
`define STROBE_LONG     6'h0F
`define MSB_LONG        6'h10
`define LEN_SHORT       6'h18
`define LEN_LONG        6'h20
`define RESULT_BITS     16
`define CAL_FALLS       6'h20
`define FIFO_DEPTH      8
`endif

// ==== adc_cmd_ext_clock.sv ====
/*
  Command-byte decoder, aux port register and external-clock conversion sequencer,
  with an 8-word result FIFO feeding the serial output shifter.
  Assumes cs_n, sclk, din come from the host asynchronously; ref_clk samples them.
  conv_result is a word from the analogue core, same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_cmd_cfg.svh"

module adc_result_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic [AW:0]      next_wr_ptr;
  logic [AW:0]      next_rd_ptr;
  logic             push;
  logic             pop;

  always_comb begin
    in_ready    = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    out_valid   = wr_ptr != rd_ptr;
    out_data    = mem[rd_ptr[AW-1:0]];
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule

module adc_cmd_ext_clock
  import adc_cmd_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        din,
  input  wire logic [15:0] conv_result,
  output logic             dout,
  output logic             dout_oe,
  output logic             conversion_strobe,
  output logic             strobe_oe,
  output logic             aux_output_two,
  output logic             aux_output_one,
  output logic             aux_output_zero,
  output logic             polarity_select,
  output logic             clock_source_select,
  output logic             power_down,
  output logic             cal_busy
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] cs_sync;
  logic [1:0] sclk_sync;
  logic [1:0] din_sync;
  logic       sclk_last;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cs_sync   <= 2'h3;
      sclk_sync <= 2'h0;
      din_sync  <= 2'h0;
      sclk_last <= 1'b0;
    end else begin
      cs_sync   <= {cs_sync[0], cs_n};
      sclk_sync <= {sclk_sync[0], sclk};
      din_sync  <= {din_sync[0], din};
      sclk_last <= sclk_sync[1];
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_low;
  logic cs_fell;
  logic cs_last;
  assign sclk_rise = sclk_sync[1] && !sclk_last;
  assign sclk_fall = !sclk_sync[1] && sclk_last;
  assign cs_low    = !cs_sync[1];
  assign cs_fell   = cs_low && cs_last;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  seq_state_t  state;
  seq_state_t  next_state;
  logic [7:0]  shreg;
  logic [7:0]  next_shreg;
  logic [2:0]  bit_cnt;
  logic [2:0]  next_bit_cnt;
  logic [5:0]  fall_cnt;
  logic [5:0]  next_fall_cnt;
  command_t    cmd;
  command_t    next_cmd;
  logic [15:0] out_sh;
  logic [15:0] next_out_sh;
  logic        next_dout;
  logic        next_strobe;
  logic        next_pdown;
  logic        next_cal;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [15:0] fifo_out_data;
  logic        fifo_pop;

  function automatic logic [5:0] run_len(input op_mode_t m);
    run_len = (m == MODE_LONG) ? `LEN_LONG :
              (m == MODE_CAL) ? `CAL_FALLS : `LEN_SHORT;
  endfunction

  always_comb begin
    next_state    = state;
    next_shreg    = shreg;
    next_bit_cnt  = bit_cnt;
    next_fall_cnt = fall_cnt;
    next_cmd      = cmd;
    next_out_sh   = out_sh;
    next_dout     = dout;
    next_strobe   = 1'b0;
    next_pdown    = power_down;
    next_cal      = cal_busy;
    fifo_pop      = 1'b0;
    if (!cs_low) begin
      // serial port disabled; a later start bit may abort a conversion
      if (state == ST_WAIT_CS) begin
        next_state = ST_IDLE;
      end
      next_dout = 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (sclk_rise && din_sync[1]) begin
            next_shreg    = 8'h01;
            next_bit_cnt  = 3'h1;
            next_fall_cnt = 6'h00;
            next_state    = ST_CMD;
          end
        end
        ST_CMD: begin
          if (sclk_fall) begin
            next_fall_cnt = fall_cnt + 6'h01;
          end
          if (sclk_rise) begin
            next_shreg   = {shreg[6:0], din_sync[1]};
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
              next_cmd = command_t'(next_shreg[6:0]);
              next_pdown = (op_mode_t'(next_shreg[4:3]) == MODE_PDOWN);
              next_cal   = (op_mode_t'(next_shreg[4:3]) == MODE_CAL);
              if (next_shreg[4:3] == 2'h2 || next_shreg[5]) begin
                next_state = ST_WAIT_CS;
              end else begin
                next_state = ST_RUN;
              end
            end
          end
          // conversion starts before the byte is whole: mode comes from the partial shift
          if (sclk_fall && bit_cnt == 3'h7) begin
            next_fall_cnt = fall_cnt + 6'h01;
            if (shreg[3:2] == 2'h0 && !shreg[4]) begin
              next_strobe = 1'b1;
            end
          end
        end
        ST_RUN: begin
          if (sclk_fall) begin
            next_fall_cnt = fall_cnt + 6'h01;
            if (cmd.mode == MODE_LONG && fall_cnt + 6'h01 == `STROBE_LONG) begin
              next_strobe = 1'b1;
            end
            if (!cal_busy &&
                ((cmd.mode == MODE_SHORT && fall_cnt + 6'h01 == `MSB_SHORT) ||
                 (cmd.mode == MODE_LONG && fall_cnt + 6'h01 == `MSB_LONG))) begin
              next_out_sh = {fifo_out_data[14:0], 1'b0};
              next_dout   = fifo_out_data[15];
              fifo_pop    = fifo_out_valid;
            end else begin
              next_dout   = out_sh[15];
              next_out_sh = {out_sh[14:0], 1'b0};
            end
            if (fall_cnt + 6'h01 == run_len(cmd.mode)) begin
              next_cal   = 1'b0;
              next_state = ST_IDLE;
            end
          end
          if (sclk_rise && din_sync[1] && fall_cnt > 6'h08) begin
            // a fresh start bit after more than eight falls aborts the conversion under way
            next_shreg    = 8'h01;
            next_bit_cnt  = 3'h1;
            next_fall_cnt = 6'h00;
            next_cal      = 1'b0;
            next_state    = ST_CMD;
          end
        end
        ST_WAIT_CS: begin
          if (cs_fell) begin
            next_state = ST_IDLE;
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state             <= ST_IDLE;
      shreg             <= 8'h00;
      bit_cnt           <= 3'h0;
      fall_cnt          <= 6'h00;
      cmd               <= command_t'(`CMD_RESET);
      out_sh            <= 16'h0000;
      dout              <= 1'b0;
      conversion_strobe <= 1'b0;
      power_down        <= 1'b0;
      cal_busy          <= 1'b0;
      cs_last           <= 1'b1;
    end else begin
      state             <= next_state;
      shreg             <= next_shreg;
      bit_cnt           <= next_bit_cnt;
      fall_cnt          <= next_fall_cnt;
      cmd               <= next_cmd;
      out_sh            <= next_out_sh;
      dout              <= next_dout;
      conversion_strobe <= next_strobe;
      power_down        <= next_pdown;
      cal_busy          <= next_cal;
      cs_last           <= !cs_low;
    end
  end

  // ---------------------------------------------------------------
  // registered pin outputs
  // ---------------------------------------------------------------
  // aux pins keep driving through power-down; nothing but reset or a new byte moves them
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      aux_output_two      <= 1'b0;
      aux_output_one      <= 1'b0;
      aux_output_zero     <= 1'b0;
      polarity_select     <= 1'b0;
      clock_source_select <= 1'b1;
      dout_oe             <= 1'b0;
      strobe_oe           <= 1'b0;
    end else begin
      {aux_output_two, aux_output_one, aux_output_zero} <= next_cmd.aux;
      polarity_select     <= next_cmd.polarity_select;
      clock_source_select <= next_cmd.clock_source_select;
      dout_oe             <= cs_low;
      strobe_oe           <= cs_low;
    end
  end

  // ---------------------------------------------------------------
  // result buffer
  // ---------------------------------------------------------------
  // core results wait here; a full buffer simply drops the word offered on that one-cycle conversion_strobe
  adc_result_fifo #(.WIDTH(`RESULT_BITS), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .in_data   (conv_result),
    .in_valid  (conversion_strobe),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  strobe_one_cycle_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    conversion_strobe |=> !conversion_strobe) else $error("strobe longer than one cycle");
  strobe_short_count_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (conversion_strobe && state == ST_CMD) |->
      (fall_cnt == `STROBE_SHORT && shreg[3:2] == 2'h0 && !shreg[4]))
    else $error("short strobe at wrong edge");
  strobe_long_count_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (conversion_strobe && state != ST_CMD) |->
      (fall_cnt == `STROBE_LONG && cmd.mode == MODE_LONG))
    else $error("long strobe at wrong edge");
  strobe_mode_only_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    conversion_strobe |-> ((state == ST_CMD) ? (shreg[3] == shreg[2]) :
      (cmd.mode == MODE_SHORT || cmd.mode == MODE_LONG)))
    else $error("strobe in calibration or power-down");
  pdown_mode_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    power_down |-> cmd.mode == MODE_PDOWN) else $error("power-down without its mode");
  aux_follow_cmd_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state == ST_CMD && cs_low && sclk_rise && bit_cnt == 3'h7) |=>
      {aux_output_two, aux_output_one, aux_output_zero} == $past({shreg[1:0], din_sync[1]}))
    else $error("aux pins do not follow command");
  aux_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !(state == ST_CMD && cs_low && sclk_rise && bit_cnt == 3'h7) |=>
      $stable({aux_output_two, aux_output_one, aux_output_zero}))
    else $error("aux pins moved without a new byte");
  start_bit_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state == ST_IDLE && cs_low && sclk_rise && din_sync[1]) |=> state == ST_CMD)
    else $error("start bit not taken");
endmodule

`default_nettype wire

// ==== adc_cmd_pkg.sv ====
/*
  Types for the command-byte decoder.
  Assumes adc_cmd_cfg.svh is on the include path.
*/
`include "adc_cmd_cfg.svh"
package adc_cmd_pkg;
  typedef enum logic [1:0] {
    MODE_SHORT,
    MODE_CAL,
    MODE_PDOWN,
    MODE_LONG
  } op_mode_t;
  typedef struct packed {
    logic     polarity_select;
    logic     clock_source_select;
    op_mode_t mode;
    logic [2:0] aux;
  } command_t;
  typedef enum {
    ST_IDLE,
    ST_CMD,
    ST_RUN,
    ST_WAIT_CS
  } seq_state_t;
endpackage

// ==== adc_command_byte_ext_clock_tb.sv ====
/*
  Self-checking bench for the command-byte decoder and external-clock sequencer.
  Assumes adc_host_model drives the serial pins and conv_result is held per frame.
*/
`timescale 1ns/1ps
`default_nettype none

module adc_command_byte_ext_clock_tb;
  logic        ref_clk;
  logic        nrst;
  logic [15:0] conv_result;
  logic        cs_n;
  logic        sclk;
  logic        din;
  logic        dout;
  logic        dout_oe;
  logic        strobe_oe;
  logic        conversion_strobe;
  logic        aux_output_two;
  logic        aux_output_one;
  logic        aux_output_zero;
  logic        polarity_select;
  logic        clock_source_select;
  logic        power_down;
  logic        cal_busy;
  logic [15:0] rx;
  logic [15:0] st;
  int          falls;
  int          strobes;
  int          strobe_at;
  int          errors;
  int          tests_run;

  // [6] polarity [5] clock source [4] power-down [3] calibrating [2:0] aux
  assign st = {9'h000, polarity_select, clock_source_select, power_down, cal_busy,
               aux_output_two, aux_output_one, aux_output_zero};

  adc_cmd_ext_clock adc_cmd_ext_clock_i (
    .ref_clk             (ref_clk),
    .nrst                (nrst),
    .cs_n                (cs_n),
    .sclk                (sclk),
    .din                 (din),
    .conv_result         (conv_result),
    .dout                (dout),
    .dout_oe             (dout_oe),
    .conversion_strobe   (conversion_strobe),
    .strobe_oe           (strobe_oe),
    .aux_output_two      (aux_output_two),
    .aux_output_one      (aux_output_one),
    .aux_output_zero     (aux_output_zero),
    .polarity_select     (polarity_select),
    .clock_source_select (clock_source_select),
    .power_down          (power_down),
    .cal_busy            (cal_busy)
  );

  adc_host_model adc_host_model_i (
    .ref_clk (ref_clk),
    .dout    (dout),
    .cs_n    (cs_n),
    .sclk    (sclk),
    .din     (din),
    .rx      (rx),
    .falls   (falls)
  );

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // a strobe longer than one cycle shows up as a count above one
  always @(posedge ref_clk) begin
    if (conversion_strobe === 1'b1) begin
      strobes   = strobes + 1;
      strobe_at = falls;
    end
  end

  // ---------------------------------------------------------------
  // checking and ending
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // one framed transfer: three leading zeros, then n shift clocks from the start bit; settle time lets the command land
  task automatic frame(input logic [7:0] b, input int n);
    strobes   = 0;
    strobe_at = 0;
    adc_host_model_i.select(1'b0);
    adc_host_model_i.send_byte(b, 3);
    repeat (n - 8) adc_host_model_i.pulse(1'b0);
    repeat (4) @(negedge ref_clk);
    check("dout_oe", {15'h0000, dout_oe}, 16'h0001);
    check("strobe_oe", {15'h0000, strobe_oe}, 16'h0001);
    adc_host_model_i.select(1'b1);
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    nrst        = 1'b0;
    conv_result = 16'hA5C3;
    errors      = 0;
    tests_run   = 0;
    strobes     = 0;
    strobe_at   = 0;
    repeat (10) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (4) @(negedge ref_clk);
    check("reset state", st, 16'h0020);

    frame(8'hC5, 24);
    check("short strobe fall", strobe_at[15:0], 16'h0007);
    check("short strobe width", strobes[15:0], 16'h0001);
    check("short result", rx, 16'hA5C3);
    check("short state", st, 16'h0045);
    check("dout idle", {13'h0000, strobe_oe, dout_oe, dout}, 16'h0000);

    conv_result = 16'h3C96;
    frame(8'h9A, 32);
    check("long strobe fall", strobe_at[15:0], 16'h000F);
    check("long strobe width", strobes[15:0], 16'h0001);
    check("long result", rx, 16'h3C96);
    check("long state", st, 16'h0002);

    frame(8'hE3, 24);
    check("internal strobes", strobes[15:0], 16'h0000);
    check("internal state", st, 16'h0063);

    adc_host_model_i.select(1'b0);
    adc_host_model_i.send_byte(8'h8E, 3);
    repeat (4) @(negedge ref_clk);
    check("cal start", st, 16'h000E);
    repeat (34) adc_host_model_i.pulse(1'b0);
    check("cal end", st, 16'h0006);
    adc_host_model_i.select(1'b1);

    frame(8'h91, 16);
    check("pdown strobes", strobes[15:0], 16'h0000);
    check("pdown state", st, 16'h0011);

    // reset in mid-frame returns the port register to its reset value
    adc_host_model_i.select(1'b0);
    adc_host_model_i.send_byte(8'hC7, 2);
    nrst = 1'b0;
    repeat (2) @(negedge ref_clk);
    check("mid reset", st, 16'h0020);
    nrst = 1'b1;
    adc_host_model_i.select(1'b1);

    // a full conversion after the mid-run reset
    conv_result = 16'h5A0F;
    frame(8'h87, 24);
    check("after reset strobe", strobes[15:0], 16'h0001);
    check("after reset result", rx, 16'h5A0F);
    check("after reset state", st, 16'h0007);
    end_sim();
  end

  // about 80 us of traffic expected
  initial begin
    #400000;
    errors++;
    end_sim();
  end
endmodule

`default_nettype wire

// ==== adc_host_model.sv ====
/*
  Host-side serial master model for the command-byte decoder: drives chip select,
  shift clock and command bits, and collects the serial result.
  Assumes ref_clk is the bench clock; every change lands on its falling edge.
*/
`timescale 1ns/1ps
`default_nettype none

module adc_host_model (
  input  wire logic   ref_clk,
  input  wire logic   dout,
  output logic        cs_n,
  output logic        sclk,
  output logic        din,
  output logic [15:0] rx,
  output int          falls
);
  initial begin
    cs_n  = 1'b1;
    sclk  = 1'b0;
    din   = 1'b0;
    rx    = 16'h0000;
    falls = 0;
  end

  // ---------------------------------------------------------------
  // shift clock
  // ---------------------------------------------------------------
  // 400 ns period; clock stands low between calls, so it is idle outside frames
  task automatic pulse(input logic d);
    din = d;
    repeat (4) @(negedge ref_clk);
    sclk = 1'b1;
    // dout moved on the previous fall, so it has settled by this rise
    rx   = {rx[14:0], dout};
    repeat (4) @(negedge ref_clk);
    sclk  = 1'b0;
    falls = falls + 1;
  endtask

  // leading zeros are ignored; fall count restarts with the start bit
  task automatic send_byte(input logic [7:0] b, input int lead);
    repeat (lead) pulse(1'b0);
    falls = 0;
    for (int i = 7; i >= 0; i--) pulse(b[i]);
  endtask

  task automatic select(input logic v);
    @(negedge ref_clk);
    cs_n = v;
    repeat (3) @(negedge ref_clk);
  endtask
endmodule

`default_nettype wire
